// ### boot_pkg.sv
`default_nettype none
package boot_pkg;

	// ==========================================================
	// Clock and serial clock rates
	localparam int unsigned CLK_KHZ       = 200000;
	localparam int unsigned QUAD_SCLK_KHZ = 50000;
	localparam int unsigned SPI_SCLK_KHZ  = 2500;
	localparam logic [7:0]  HALF_QUAD     = 8'(CLK_KHZ / (2 * QUAD_SCLK_KHZ));
	localparam logic [7:0]  HALF_SPI      = 8'(CLK_KHZ / (2 * SPI_SCLK_KHZ));

	// ==========================================================
	// Flash command and image format
	localparam logic [7:0]  READ_CMD      = 8'h03;
	localparam logic [23:0] START_ADDR    = 24'h000000;
	localparam logic [5:0]  CMD_BITS      = 6'h20;
	localparam logic [31:0] NO_CRC_WORD   = 32'h0D15AB1E;
	localparam logic [31:0] CRC_POLY      = 32'hEDB88320;
	localparam logic [31:0] CRC_PRESET    = 32'hFFFFFFFF;

	// ==========================================================
	// Pin enables, RAM and buffer sizes
	localparam logic [3:0]  QD_CMD_OE_N   = 4'hE;
	localparam logic [3:0]  QD_OFF_OE_N   = 4'hF;
	localparam int unsigned RAM_AW        = 18;
	localparam logic [17:0] RAM_BASE      = 18'h00000;
	localparam int unsigned FIFO_DEPTH    = 8;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		S_WAIT_LOCK = 3'h0,
		S_CMD       = 3'h1,
		S_RECV      = 3'h2,
		S_DRAIN     = 3'h3,
		S_DONE      = 3'h4,
		S_FAIL      = 3'h5
	} state_t;

	typedef enum logic [1:0] {
		F_SIZE = 2'h0,
		F_PROG = 2'h1,
		F_CHK  = 2'h2
	} field_t;

	typedef struct packed {
		logic [RAM_AW-1:0] addr;
		logic [7:0]        data;
	} ram_wr_t;

endpackage : boot_pkg
`default_nettype wire

// ### byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [CW-1:0]    count_r;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign in_ready  = (count_r != CW'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data  = mem[rd_ptr_r];

	// ==========================================================
	// Storage and pointers
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			end
			count_r <= count_r + CW'(push) - CW'(pop);
		end
	end

endmodule : byte_fifo
`default_nettype wire

// ### crc32_byte.sv
`timescale 1ns/1ps
`default_nettype none
module crc32_byte (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Byte stream
	input  wire logic        init,
	input  wire logic        en,
	input  wire logic [7:0]  data,
	// Running register
	output logic [31:0]      crc
);

	logic [31:0] crc_r;
	logic [31:0] crc_nxt;

	// ==========================================================
	// Reflected update, one byte per cycle
	always_comb begin
		crc_nxt = crc_r ^ {24'h000000, data};
		for (int i = 0; i < 8; i++) begin
			crc_nxt = crc_nxt[0] ? ((crc_nxt >> 1) ^ boot_pkg::CRC_POLY) : (crc_nxt >> 1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			crc_r <= boot_pkg::CRC_PRESET;
		end else if (init) begin
			crc_r <= boot_pkg::CRC_PRESET;
		end else if (en) begin
			crc_r <= crc_nxt;
		end
	end

	assign crc = crc_r;

endmodule : crc32_byte
`default_nettype wire

// ### flash_boot.sv
// What this block does
// - Quad boot drives select, clock and data line 0, reads four data lines; clock 50 MHz.
// - Single-bit boot uses in, out, select and clock; clock 2.5 MHz.
// - Every boot starts with READ command and a 24-bit zero address.
// - Serial clock idles low; read data sampled at the falling edge.
// - Quad image bytes arrive as two nibbles, low nibble first.
// - Single-bit image bytes arrive least significant bit first.
// - Quad boot pins are fixed and cannot be changed.
// - Image ends in a 32-bit check word; a sentinel skips CRC.
// - Length field and check word are assembled low byte first.
// - Program goes to RAM from lowest address and starts there.
// - CRC covers the length bytes then every program byte in order.
// - CRC reflected polynomial, preset all ones, final value inverted.
// - Reset is active low, asynchronous; boot waits for clock lock.
`timescale 1ns/1ps
`default_nettype none
module flash_boot (
	// Clock and reset
	input  wire logic                         CLK,
	input  wire logic                         RST_N,
	// Clock lock and boot strap
	input  wire logic                         PLL_LOCK,
	input  wire logic                         BOOT_QUAD,
	// Flash pins
	output logic                              SEL_N,
	output logic                              SCLK,
	output logic                              MOSI,
	input  wire logic                         MISO,
	input  wire logic [3:0]                   QD_I,
	output logic [3:0]                        QD_O,
	output logic [3:0]                        QD_OE_N,
	// RAM write port
	output logic                              RAM_WE,
	output logic [boot_pkg::RAM_AW-1:0]       RAM_ADDR,
	output logic [7:0]                        RAM_WDATA,
	input  wire logic                         RAM_READY,
	// Boot result
	output logic                              BOOT_DONE,
	output logic                              BOOT_FAIL,
	output logic                              EXEC_START,
	output logic [boot_pkg::RAM_AW-1:0]       EXEC_ADDR
);

	// ==========================================================
	// Input synchronisers
	logic [6:0] sync1_r;
	logic [6:0] sync2_r;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_r <= 7'h00;
			sync2_r <= 7'h00;
		end else begin
			sync1_r <= {PLL_LOCK, BOOT_QUAD, MISO, QD_I};
			sync2_r <= sync1_r;
		end
	end

	wire       lock_s = sync2_r[6];
	wire       quad_s = sync2_r[5];
	wire       miso_s = sync2_r[4];
	wire [3:0] qd_s   = sync2_r[3:0];

	// ==========================================================
	// State
	boot_pkg::state_t          state_r;
	boot_pkg::field_t          field_r;
	logic                      quad_r;
	logic                      sel_n_r;
	logic                      sclk_r;
	logic [7:0]                half_cnt_r;
	logic [5:0]                bit_cnt_r;
	logic [31:0]               tx_sr_r;
	logic [7:0]                rx_sr_r;
	logic [3:0]                qd_oe_n_r;
	logic [1:0]                idx_r;
	logic [31:0]               len_r;
	logic [31:0]               left_r;
	logic [31:0]               chk_r;
	logic [boot_pkg::RAM_AW-1:0] wr_addr_r;
	logic                      ram_we_r;
	boot_pkg::ram_wr_t         ram_r;
	logic                      done_r;
	logic                      fail_r;
	logic                      start_r;
	logic [boot_pkg::RAM_AW-1:0] exec_addr_r;

	// ==========================================================
	// Decode
	logic              fifo_in_ready;
	logic              fifo_out_valid;
	boot_pkg::ram_wr_t fifo_out;
	logic [31:0]       crc_val;

	wire       running   = (state_r == boot_pkg::S_CMD) || (state_r == boot_pkg::S_RECV);
	wire [7:0] half_load = quad_r ? (boot_pkg::HALF_QUAD - 8'h01) : (boot_pkg::HALF_SPI - 8'h01);
	wire       stall     = (state_r == boot_pkg::S_RECV) && (bit_cnt_r == 6'h00) && !sclk_r
	                       && (field_r == boot_pkg::F_PROG) && !fifo_in_ready;
	wire       tick      = running && !stall && (half_cnt_r == 8'h00);
	wire       fall      = tick && sclk_r;
	wire [5:0] last_bit  = quad_r ? 6'h01 : 6'h07;
	wire [7:0] rx_nxt    = quad_r ? {qd_s, rx_sr_r[7:4]} : {miso_s, rx_sr_r[7:1]};
	wire       byte_done = fall && (state_r == boot_pkg::S_RECV) && (bit_cnt_r == last_bit);
	wire       last_idx  = (idx_r == 2'h3);
	wire [31:0] len_nxt  = {rx_nxt, len_r[31:8]};
	wire [31:0] chk_nxt  = {rx_nxt, chk_r[31:8]};
	wire       push      = byte_done && (field_r == boot_pkg::F_PROG);
	wire       crc_en    = byte_done && (field_r != boot_pkg::F_CHK);
	wire       crc_init  = (state_r == boot_pkg::S_WAIT_LOCK);
	wire       crc_ok    = (chk_r == boot_pkg::NO_CRC_WORD) || (chk_r == ~crc_val);
	wire       drained   = !fifo_out_valid && !ram_we_r;
	wire       fifo_out_ready = !ram_we_r || RAM_READY;

	// ==========================================================
	// Serial clock and shifters
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sclk_r     <= 1'b0;
			half_cnt_r <= 8'h00;
			bit_cnt_r  <= 6'h00;
			tx_sr_r    <= 32'h00000000;
			rx_sr_r    <= 8'h00;
		end else if (state_r == boot_pkg::S_WAIT_LOCK) begin
			sclk_r     <= 1'b0;
			half_cnt_r <= half_load;
			bit_cnt_r  <= 6'h00;
			tx_sr_r    <= {boot_pkg::READ_CMD, boot_pkg::START_ADDR};
		end else if (running && !stall) begin
			half_cnt_r <= tick ? half_load : half_cnt_r - 8'h01;
			if (tick) begin
				sclk_r <= !sclk_r;
			end
			if (fall && (state_r == boot_pkg::S_CMD)) begin
				tx_sr_r   <= {tx_sr_r[30:0], 1'b0};
				bit_cnt_r <= (bit_cnt_r == boot_pkg::CMD_BITS - 6'h01) ? 6'h00 : bit_cnt_r + 6'h01;
			end
			if (fall && (state_r == boot_pkg::S_RECV)) begin
				rx_sr_r   <= rx_nxt;
				bit_cnt_r <= byte_done ? 6'h00 : bit_cnt_r + 6'h01;
			end
		end
	end

	// ==========================================================
	// Boot sequence
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_r     <= boot_pkg::S_WAIT_LOCK;
			field_r     <= boot_pkg::F_SIZE;
			quad_r      <= 1'b0;
			sel_n_r     <= 1'b1;
			qd_oe_n_r   <= boot_pkg::QD_OFF_OE_N;
			idx_r       <= 2'h0;
			len_r       <= 32'h00000000;
			left_r      <= 32'h00000000;
			chk_r       <= 32'h00000000;
			wr_addr_r   <= boot_pkg::RAM_BASE;
			done_r      <= 1'b0;
			fail_r      <= 1'b0;
			start_r     <= 1'b0;
			exec_addr_r <= boot_pkg::RAM_BASE;
		end else begin
			start_r <= 1'b0;
			case (state_r)
				boot_pkg::S_WAIT_LOCK: begin
					quad_r <= quad_s;
					if (lock_s) begin
						state_r   <= boot_pkg::S_CMD;
						sel_n_r   <= 1'b0;
						qd_oe_n_r <= quad_s ? boot_pkg::QD_CMD_OE_N : boot_pkg::QD_OFF_OE_N;
						field_r   <= boot_pkg::F_SIZE;
						idx_r     <= 2'h0;
						wr_addr_r <= boot_pkg::RAM_BASE;
					end
				end
				boot_pkg::S_CMD: begin
					if (fall && (bit_cnt_r == boot_pkg::CMD_BITS - 6'h01)) begin
						state_r   <= boot_pkg::S_RECV;
						qd_oe_n_r <= boot_pkg::QD_OFF_OE_N;
					end
				end
				boot_pkg::S_RECV: begin
					if (byte_done) begin
						idx_r <= idx_r + 2'h1;
						case (field_r)
							boot_pkg::F_SIZE: begin
								len_r <= len_nxt;
								if (last_idx) begin
									left_r  <= len_nxt;
									field_r <= (len_nxt == 32'h00000000) ? boot_pkg::F_CHK : boot_pkg::F_PROG;
								end
							end
							boot_pkg::F_PROG: begin
								wr_addr_r <= wr_addr_r + 1'b1;
								left_r    <= left_r - 32'h00000001;
								idx_r     <= 2'h0;
								if (left_r == 32'h00000001) begin
									field_r <= boot_pkg::F_CHK;
								end
							end
							default: begin
								chk_r <= chk_nxt;
								if (last_idx) begin
									state_r <= boot_pkg::S_DRAIN;
									sel_n_r <= 1'b1;
								end
							end
						endcase
					end
				end
				boot_pkg::S_DRAIN: begin
					if (drained) begin
						if (crc_ok) begin
							state_r     <= boot_pkg::S_DONE;
							done_r      <= 1'b1;
							start_r     <= 1'b1;
							exec_addr_r <= boot_pkg::RAM_BASE;
						end else begin
							state_r <= boot_pkg::S_FAIL;
							fail_r  <= 1'b1;
						end
					end
				end
				boot_pkg::S_DONE: begin
					state_r <= boot_pkg::S_DONE;
				end
				default: begin
					state_r <= boot_pkg::S_FAIL;
				end
			endcase
		end
	end

	// ==========================================================
	// Buffer and RAM write stage
	byte_fifo #(
		.WIDTH ($bits(boot_pkg::ram_wr_t)),
		.DEPTH (boot_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK),
		.rst_n     (RST_N),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   ({wr_addr_r, rx_nxt}),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out)
	);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ram_we_r <= 1'b0;
			ram_r    <= '0;
		end else if (fifo_out_valid && fifo_out_ready) begin
			ram_we_r <= 1'b1;
			ram_r    <= fifo_out;
		end else if (RAM_READY) begin
			ram_we_r <= 1'b0;
		end
	end

	crc32_byte u_crc (
		.clk   (CLK),
		.rst_n (RST_N),
		.init  (crc_init),
		.en    (crc_en),
		.data  (rx_nxt),
		.crc   (crc_val)
	);

	// ==========================================================
	// Outputs
	assign SEL_N      = sel_n_r;
	assign SCLK       = sclk_r;
	assign MOSI       = tx_sr_r[31];
	assign QD_O       = {3'h0, tx_sr_r[31]};
	assign QD_OE_N    = qd_oe_n_r;
	assign RAM_WE     = ram_we_r;
	assign RAM_ADDR   = ram_r.addr;
	assign RAM_WDATA  = ram_r.data;
	assign BOOT_DONE  = done_r;
	assign BOOT_FAIL  = fail_r;
	assign EXEC_START = start_r;
	assign EXEC_ADDR  = exec_addr_r;

	// ==========================================================
	// Checks
	logic [7:0] hi_len_r;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			hi_len_r <= 8'h00;
		end else begin
			hi_len_r <= sclk_r ? hi_len_r + 8'h01 : 8'h00;
		end
	end

	sequence s_quad_high;
		sclk_r[*2] ##1 !sclk_r;
	endsequence

	property p_cmd_word;
		@(posedge CLK) disable iff (!RST_N)
		$fell(sel_n_r) |-> (tx_sr_r == {boot_pkg::READ_CMD, boot_pkg::START_ADDR}) && !sclk_r;
	endproperty
	a_cmd_word: assert property (p_cmd_word) else $error("Command word wrong at select");

	property p_idle_low;
		@(posedge CLK) disable iff (!RST_N)
		sel_n_r |-> !sclk_r;
	endproperty
	a_idle_low: assert property (p_idle_low) else $error("Serial clock high while idle");

	property p_quad_rate;
		@(posedge CLK) disable iff (!RST_N)
		($rose(sclk_r) && quad_r) |-> s_quad_high;
	endproperty
	a_quad_rate: assert property (p_quad_rate) else $error("Quad clock high phase wrong");

	property p_spi_rate;
		@(posedge CLK) disable iff (!RST_N)
		($fell(sclk_r) && !quad_r) |-> (hi_len_r == boot_pkg::HALF_SPI);
	endproperty
	a_spi_rate: assert property (p_spi_rate) else $error("Single clock high phase wrong");

	property p_quad_pins;
		@(posedge CLK) disable iff (!RST_N)
		(state_r == boot_pkg::S_RECV) |-> (qd_oe_n_r == boot_pkg::QD_OFF_OE_N);
	endproperty
	a_quad_pins: assert property (p_quad_pins) else $error("Data lines driven while reading");

	property p_lock_wait;
		@(posedge CLK) disable iff (!RST_N)
		((state_r == boot_pkg::S_WAIT_LOCK) && !lock_s) |=> (state_r == boot_pkg::S_WAIT_LOCK) && sel_n_r;
	endproperty
	a_lock_wait: assert property (p_lock_wait) else $error("Boot began before lock");

	property p_fail_flag;
		@(posedge CLK) disable iff (!RST_N)
		$rose(fail_r) |-> (chk_r != boot_pkg::NO_CRC_WORD) && (chk_r != ~crc_val) && !done_r;
	endproperty
	a_fail_flag: assert property (p_fail_flag) else $error("Failure raised on good image");

	property p_start;
		@(posedge CLK) disable iff (!RST_N)
		start_r |-> done_r && !fail_r && (exec_addr_r == boot_pkg::RAM_BASE) && !fifo_out_valid ##1 !start_r;
	endproperty
	a_start: assert property (p_start) else $error("Start pulse wrong");

	property p_no_overrun;
		@(posedge CLK) disable iff (!RST_N)
		push |-> fifo_in_ready;
	endproperty
	a_no_overrun: assert property (p_no_overrun) else $error("Byte pushed into full buffer");

endmodule : flash_boot
`default_nettype wire

// ### flash_boot_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module flash_boot_tb_top;
	// ==========
	// Signals
	logic        CLK, RST_N, PLL_LOCK, BOOT_QUAD, RAM_READY;
	logic        SEL_N, SCLK, MOSI, MISO, RAM_WE, BOOT_DONE, BOOT_FAIL, EXEC_START;
	logic [3:0]  QD_O, QD_OE_N, fl_qd, qd_line, lag;
	logic [17:0] RAM_ADDR, EXEC_ADDR;
	logic [7:0]  RAM_WDATA, half_exp;
	logic [7:0]  prog [0:31];
	logic [31:0] cyc;
	logic        stall;
	int          miscompares, cmp_count, wr_cnt, exec_cnt, hi_cnt;

	assign qd_line = (QD_OE_N & fl_qd) | (~QD_OE_N & QD_O);

	flash_boot dut_u (.CLK(CLK), .RST_N(RST_N), .PLL_LOCK(PLL_LOCK), .BOOT_QUAD(BOOT_QUAD),
		.SEL_N(SEL_N), .SCLK(SCLK), .MOSI(MOSI), .MISO(MISO), .QD_I(qd_line), .QD_O(QD_O),
		.QD_OE_N(QD_OE_N), .RAM_WE(RAM_WE), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA),
		.RAM_READY(RAM_READY), .BOOT_DONE(BOOT_DONE), .BOOT_FAIL(BOOT_FAIL),
		.EXEC_START(EXEC_START), .EXEC_ADDR(EXEC_ADDR));
	flash_model flash_u (.sel_n(SEL_N), .sclk(SCLK), .mosi(MOSI), .qd0(qd_line[0]), .oe_n(QD_OE_N),
		.miso(MISO), .qd(fl_qd), .quad(BOOT_QUAD), .lag(lag));

	initial begin
		CLK = 1'b0;
		RST_N = 1'b1;
		PLL_LOCK = 1'b0;
		BOOT_QUAD = 1'b0;
		RAM_READY = 1'b1;
		stall = 1'b0;
		cyc = 32'h0;
		lag = 4'h0;
		half_exp = 8'h00;
		miscompares = 0;
		cmp_count = 0;
		wr_cnt = 0;
		exec_cnt = 0;
		hi_cnt = 0;
	end
	always #2.5 CLK = ~CLK;

	// ==========
	// Checking and closing
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic stop_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test

	// ==========
	// RAM side, serial clock and start monitor
	always @(posedge CLK) begin
		cyc <= cyc + 32'h1;
		RAM_READY <= !stall || (cyc[4:0] == 5'h00);
		if (RAM_WE === 1'b1 && RAM_READY === 1'b1) begin
			chk("ram_addr", wr_cnt, RAM_ADDR);
			chk("ram_data", prog[wr_cnt], RAM_WDATA);
			wr_cnt++;
		end
		if (EXEC_START === 1'b1) begin
			chk("exec_addr", boot_pkg::RAM_BASE, EXEC_ADDR);
			exec_cnt++;
		end
		if (SEL_N !== 1'b0) chk("sclk_idle", 1'b0, SCLK);
		if (SCLK === 1'b1) begin
			hi_cnt++;
		end else begin
			if (hi_cnt != 0 && RST_N === 1'b1) chk("sclk_high", half_exp, hi_cnt);
			hi_cnt = 0;
		end
	end

	// ==========
	// Image building
	function automatic logic [31:0] crc_of(input int n);
		logic [31:0] c;
		c = boot_pkg::CRC_PRESET;
		for (int i = 0; i < n + 4; i++) begin
			c = c ^ {24'h000000, (i < 4) ? 8'(n >> (8 * i)) : prog[i - 4]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ boot_pkg::CRC_POLY : c >> 1;
		end
		return ~c;
	endfunction : crc_of

	task automatic load(input int n, input logic quad, input logic [1:0] ck);
		logic [31:0] w;
		logic [7:0]  b;
		logic [7:0]  r;
		w = (ck == 2'h1) ? boot_pkg::NO_CRC_WORD : crc_of(n) ^ {31'h0, ck[1]};
		for (int i = 0; i < n + 8; i++) begin
			b = (i < 4) ? 8'(n >> (8 * i)) : (i < n + 4) ? prog[i - 4] : 8'(w >> (8 * (i - n - 4)));
			r = {<<{b}};
			flash_u.mem[i] = quad ? {b[3:0], b[7:4]} : r;
		end
	endtask : load

	// ==========
	// One boot from reset; abort_at cuts it short by a reset
	task automatic boot(input logic quad, input int n, input logic [1:0] ck, input logic st, input int abort_at);
		int t;
		stall = st;
		for (int i = 0; i < 32; i++) prog[i] = 8'(i * 8'h25 + 8'h5A);
		load(n, quad, ck);
		half_exp = quad ? boot_pkg::HALF_QUAD : boot_pkg::HALF_SPI;
		PLL_LOCK <= 1'b0;
		BOOT_QUAD <= quad;
		RST_N <= 1'b0;
		repeat (20) @(posedge CLK);
		RST_N <= 1'b1;
		wr_cnt = 0;
		exec_cnt = 0;
		repeat (12) @(posedge CLK);
		chk("sel_n_before_lock", 1'b1, SEL_N);
		PLL_LOCK <= 1'b1;
		if (abort_at > 0) begin
			repeat (abort_at) @(posedge CLK);
			chk("sel_n_live", 1'b0, SEL_N);
			chk("oe_live", quad ? boot_pkg::QD_CMD_OE_N : boot_pkg::QD_OFF_OE_N, QD_OE_N);
			RST_N <= 1'b0;
			#1;
			chk("sel_n_async", 1'b1, SEL_N);
			chk("oe_async", boot_pkg::QD_OFF_OE_N, QD_OE_N);
			@(posedge CLK);
			return;
		end
		t = 0;
		while (BOOT_DONE !== 1'b1 && BOOT_FAIL !== 1'b1 && t < 40000) begin
			@(posedge CLK);
			t++;
		end
		if (t >= 40000) begin
			miscompares++;
			stop_test();
		end
		repeat (4) @(posedge CLK);
		chk("command", {boot_pkg::READ_CMD, boot_pkg::START_ADDR}, flash_u.cmd_r);
		chk("oe_cmd", quad ? boot_pkg::QD_CMD_OE_N : boot_pkg::QD_OFF_OE_N, flash_u.oe_cmd);
		chk("oe_read", boot_pkg::QD_OFF_OE_N, flash_u.oe_rd);
		chk("sel_n_end", 1'b1, SEL_N);
	endtask : boot

	task automatic expect_end(input logic ok, input int n);
		chk("boot_done", ok, BOOT_DONE);
		chk("boot_fail", !ok, BOOT_FAIL);
		chk("ram_writes", n, wr_cnt);
		chk("exec_pulses", ok, exec_cnt);
	endtask : expect_end

	// ==========
	// Scenarios
	task automatic sc_single_crc();
		lag = 4'h0;
		boot(1'b0, 5, 2'h0, 1'b1, 0);
		expect_end(1'b1, 5);
	endtask : sc_single_crc

	task automatic sc_quad_fill();
		lag = 4'h7;
		boot(1'b1, 24, 2'h1, 1'b1, 0);
		expect_end(1'b1, 24);
	endtask : sc_quad_fill

	task automatic sc_quad_bad();
		lag = 4'h2;
		boot(1'b1, 12, 2'h2, 1'b0, 0);
		expect_end(1'b0, 12);
	endtask : sc_quad_bad

	task automatic sc_abort();
		lag = 4'h1;
		boot(1'b1, 4, 2'h0, 1'b0, 60);
		boot(1'b0, 0, 2'h0, 1'b0, 0);
		expect_end(1'b1, 0);
	endtask : sc_abort

	initial begin
		sc_single_crc();
		sc_quad_fill();
		sc_quad_bad();
		sc_abort();
		stop_test();
	end

	initial begin
		#400000;
		miscompares++;
		stop_test();
	end
endmodule : flash_boot_tb_top
`default_nettype wire

// ### flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_model (
	// Flash pins
	input  wire logic       sel_n,
	input  wire logic       sclk,
	input  wire logic       mosi,
	input  wire logic       qd0,
	input  wire logic [3:0] oe_n,
	output logic            miso,
	output logic [3:0]      qd,
	// Set-up
	input  wire logic       quad,
	input  wire logic [3:0] lag
);
	logic [7:0]  mem [0:63];
	logic [31:0] cmd_r;
	logic [3:0]  oe_cmd;
	logic [3:0]  oe_rd;
	logic [7:0]  cur;
	int          edges;
	int          unit;

	initial begin
		miso = 1'b0;
		qd = 4'h0;
		edges = 0;
		unit = 0;
	end

	// ==========
	// Command capture on rising edges
	always @(negedge sel_n) begin
		edges = 0;
		unit = 0;
	end
	always @(posedge sclk) begin
		if (!sel_n && edges < 32) begin
			if (edges == 0) oe_cmd = oe_n;
			cmd_r = {cmd_r[30:0], quad ? qd0 : mosi};
			edges++;
		end
	end

	// ==========
	// Data after each falling edge, stored MSB or high nibble first
	always @(negedge sclk) begin
		if (!sel_n && edges >= 32) begin
			if (unit == 0) oe_rd = oe_n;
			cur = mem[6'(cmd_r[5:0] + unit / (quad ? 2 : 8))];
			miso = ~miso;
			qd = ~qd;
			#(lag);
			miso = cur[7 - unit % 8];
			qd = (unit % 2 == 0) ? cur[7:4] : cur[3:0];
			unit++;
		end
	end

	// ==========
	// Released lines lose their last value
	always @(posedge sel_n) begin
		miso = ~miso;
		qd = ~qd;
	end
endmodule : flash_model
`default_nettype wire
